// ===== design/bas_pkg.sv
// constants and types for the byte alu / bit skip / branch execution block
// assumes the core decodes opcodes and supplies operands, file data and pc
//
// Notes on behaviour
// - add accumulator and file, flags c dc z
// - destination bit 0 accumulator, 1 file
// - shift right, keep bit 7, bit 0 to carry
// - add accumulator, file and carry, route by destination
// - clear bit b of file, flags untouched
// - skip next when tested bit is zero
// - skip next when tested bit is one
// - pc becomes pc plus one plus signed offset
// - pc change or true test adds nop cycle
package bas_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int BIT_W = 3;
  localparam int OFS_W = 9;
  localparam int PC_W = 15;
  localparam int NIB_W = 4;
  localparam int MSB_POS = 7;
  localparam logic DEST_ACC = 1'b0;
  localparam logic DEST_FILE = 1'b1;
  localparam logic [DATA_W-1:0] ACC_RST = 8'h00;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [PC_W-1:0] PC_RST = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP = 15'h0001;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;

  typedef enum logic [2:0] {
    op_no_operation,
    op_add_acc_to_file,
    op_add_acc_file_with_carry,
    op_arith_shift_right_file,
    op_clear_file_bit,
    op_test_bit_skip_if_zero,
    op_test_bit_skip_if_one,
    op_relative_jump
  } bas_op_type;

  typedef enum {
    st_idle,
    st_nop_cycle
  } bas_state_type;
endpackage : bas_pkg

// ===== design/bas_exec.sv
// execution datapath for the add, shift, bit clear, bit skip and relative jump group
// assumes the core presents one decoded instruction per start pulse, with the
// addressed file register already read onto file_data_in in the same cycle
`timescale 1ns/1ps
`default_nettype none
module bas_exec
  import bas_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_W,
  parameter int PC_BITS = PC_W
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire bas_op_type op_in,
  input wire logic [ADDR_BITS-1:0] file_addr_in,
  input wire logic dest_in,
  input wire logic [BIT_W-1:0] bit_sel_in,
  input wire logic [OFS_W-1:0] offset_in,
  input wire logic [PC_BITS-1:0] pc_in,
  input wire logic [DATA_W-1:0] file_data_in,
  output logic [DATA_W-1:0] acc_out,
  output logic carry_out,
  output logic digit_carry_flag_out,
  output logic zero_out,
  output logic file_we_out,
  output logic [ADDR_BITS-1:0] file_addr_out,
  output logic [DATA_W-1:0] file_wdata_out,
  output logic pc_load_out,
  output logic [PC_BITS-1:0] pc_target_out,
  output logic discard_next_out,
  output logic busy_out,
  output logic done_out
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // returns {carry out of bit 7, carry out of bit 3, sum}
  function automatic logic [DATA_W+1:0] add_bytes(input logic [DATA_W-1:0] a,
                                                  input logic [DATA_W-1:0] b,
                                                  input logic cin);
    logic [NIB_W:0] low;
    logic [DATA_W:0] full;
    low = {1'b0, a[NIB_W-1:0]} + {1'b0, b[NIB_W-1:0]} + {{NIB_W{1'b0}}, cin};
    full = {1'b0, a} + {1'b0, b} + {{DATA_W{1'b0}}, cin};
    return {full[DATA_W], low[NIB_W], full[DATA_W-1:0]};
  endfunction : add_bytes

  function automatic logic is_zero(input logic [DATA_W-1:0] v);
    return v == DATA_ZERO;
  endfunction : is_zero

  ////////////////////////////////////////////////////////////////////////////
  // state

  bas_state_type state_reg, state_next;
  logic [DATA_W-1:0] acc_reg, acc_next;
  logic carry_reg, carry_next;
  logic dc_reg, dc_next;
  logic zero_reg, zero_next;
  logic file_we_reg, file_we_next;
  logic [ADDR_BITS-1:0] file_addr_reg, file_addr_next;
  logic [DATA_W-1:0] file_wdata_reg, file_wdata_next;
  logic pc_load_reg, pc_load_next;
  logic [PC_BITS-1:0] pc_target_reg, pc_target_next;
  logic discard_reg, discard_next;
  logic busy_reg, busy_next;
  logic done_reg, done_next;

  ////////////////////////////////////////////////////////////////////////////
  // next-state computation

  logic [DATA_W+1:0] sum_plain;
  logic [DATA_W+1:0] sum_carry;
  logic [DATA_W-1:0] shifted;
  logic [DATA_W-1:0] cleared;
  logic tested_bit;
  logic [PC_BITS-1:0] jump_target;
  logic take;

  always_comb begin
    sum_plain = add_bytes(acc_reg, file_data_in, 1'b0);
    sum_carry = add_bytes(acc_reg, file_data_in, carry_reg);
    shifted = {file_data_in[MSB_POS], file_data_in[DATA_W-1:1]};
    cleared = file_data_in & ~(DATA_ZERO | (8'h01 << bit_sel_in));
    tested_bit = file_data_in[bit_sel_in];
    // offset is sign-extended before the add, so wrap is modulo pc width
    jump_target = pc_in + PC_STEP
                  + {{(PC_BITS-OFS_W){offset_in[OFS_W-1]}}, offset_in};
    take = start_in && (state_reg == st_idle);

    state_next = state_reg;
    acc_next = acc_reg;
    carry_next = carry_reg;
    dc_next = dc_reg;
    zero_next = zero_reg;
    file_we_next = 1'b0;
    file_addr_next = file_addr_reg;
    file_wdata_next = file_wdata_reg;
    pc_load_next = 1'b0;
    pc_target_next = pc_target_reg;
    discard_next = 1'b0;
    busy_next = 1'b0;
    done_next = 1'b0;

    case (state_reg)
      st_idle: begin
        if (take) begin
          done_next = 1'b1;
          file_addr_next = file_addr_in;
          case (op_in)
            op_add_acc_to_file: begin
              carry_next = sum_plain[DATA_W+1];
              dc_next = sum_plain[DATA_W];
              zero_next = is_zero(sum_plain[DATA_W-1:0]);
              if (dest_in == DEST_FILE) begin
                file_we_next = 1'b1;
                file_wdata_next = sum_plain[DATA_W-1:0];
              end else begin
                acc_next = sum_plain[DATA_W-1:0];
              end
            end
            op_add_acc_file_with_carry: begin
              carry_next = sum_carry[DATA_W+1];
              dc_next = sum_carry[DATA_W];
              zero_next = is_zero(sum_carry[DATA_W-1:0]);
              if (dest_in == DEST_FILE) begin
                file_we_next = 1'b1;
                file_wdata_next = sum_carry[DATA_W-1:0];
              end else begin
                acc_next = sum_carry[DATA_W-1:0];
              end
            end
            op_arith_shift_right_file: begin
              carry_next = file_data_in[0];
              zero_next = is_zero(shifted);
              if (dest_in == DEST_FILE) begin
                file_we_next = 1'b1;
                file_wdata_next = shifted;
              end else begin
                acc_next = shifted;
              end
            end
            op_clear_file_bit: begin
              file_we_next = 1'b1;
              file_wdata_next = cleared;
            end
            op_test_bit_skip_if_zero: begin
              if (!tested_bit) begin
                discard_next = 1'b1;
                busy_next = 1'b1;
                done_next = 1'b0;
                state_next = st_nop_cycle;
              end
            end
            op_test_bit_skip_if_one: begin
              if (tested_bit) begin
                discard_next = 1'b1;
                busy_next = 1'b1;
                done_next = 1'b0;
                state_next = st_nop_cycle;
              end
            end
            op_relative_jump: begin
              pc_load_next = 1'b1;
              pc_target_next = jump_target;
              busy_next = 1'b1;
              done_next = 1'b0;
              state_next = st_nop_cycle;
            end
            default: begin
              // no_operation: single cycle, only file_addr_out and done_out change
            end
          endcase
        end
      end
      st_nop_cycle: begin
        // second cycle executes as a no-operation; new starts are ignored
        done_next = 1'b1;
        state_next = st_idle;
      end
      default: begin
        state_next = st_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_reg <= st_idle;
      acc_reg <= ACC_RST;
      carry_reg <= FLAG_RST;
      dc_reg <= FLAG_RST;
      zero_reg <= FLAG_RST;
      file_we_reg <= 1'b0;
      file_addr_reg <= ADDR_RST;
      file_wdata_reg <= DATA_ZERO;
      pc_load_reg <= 1'b0;
      pc_target_reg <= PC_RST;
      discard_reg <= 1'b0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else if (clk_en_in) begin
      state_reg <= state_next;
      acc_reg <= acc_next;
      carry_reg <= carry_next;
      dc_reg <= dc_next;
      zero_reg <= zero_next;
      file_we_reg <= file_we_next;
      file_addr_reg <= file_addr_next;
      file_wdata_reg <= file_wdata_next;
      pc_load_reg <= pc_load_next;
      pc_target_reg <= pc_target_next;
      discard_reg <= discard_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign acc_out = acc_reg;
  assign carry_out = carry_reg;
  assign digit_carry_flag_out = dc_reg;
  assign zero_out = zero_reg;
  assign file_we_out = file_we_reg;
  assign file_addr_out = file_addr_reg;
  assign file_wdata_out = file_wdata_reg;
  assign pc_load_out = pc_load_reg;
  assign pc_target_out = pc_target_reg;
  assign discard_next_out = discard_reg;
  assign busy_out = busy_reg;
  assign done_out = done_reg;

endmodule : bas_exec
`default_nettype wire

// ===== verification/bas_exec_checker.sv
// concurrent checks on the ports of bas_exec
// assumes one clock domain and the synchronous reset of the top module
`timescale 1ns/1ps
`default_nettype none
module bas_exec_checker
  import bas_pkg::*;
#(parameter int ADDR_BITS = ADDR_W, parameter int PC_BITS = PC_W) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic clk_en_in,
  input wire logic start_in,
  input wire bas_op_type op_in,
  input wire logic [ADDR_BITS-1:0] file_addr_in,
  input wire logic dest_in,
  input wire logic [BIT_W-1:0] bit_sel_in,
  input wire logic [OFS_W-1:0] offset_in,
  input wire logic [PC_BITS-1:0] pc_in,
  input wire logic [DATA_W-1:0] file_data_in,
  input wire logic [DATA_W-1:0] acc_out,
  input wire logic carry_out,
  input wire logic digit_carry_flag_out,
  input wire logic zero_out,
  input wire logic file_we_out,
  input wire logic [ADDR_BITS-1:0] file_addr_out,
  input wire logic [DATA_W-1:0] file_wdata_out,
  input wire logic pc_load_out,
  input wire logic [PC_BITS-1:0] pc_target_out,
  input wire logic discard_next_out,
  input wire logic busy_out
  , input wire logic done_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // the nop cycle is exactly the cycle busy_out is high
  logic tk, tb;
  logic [8:0] sum;
  logic [PC_BITS-1:0] tgt;
  assign tk = clk_en_in & start_in & !busy_out;
  assign tb = file_data_in[bit_sel_in];
  assign sum = acc_out + file_data_in;
  assign tgt = pc_in + 1'b1 + {{(PC_BITS-OFS_W){offset_in[OFS_W-1]}}, offset_in};
  logic [DATA_W-1:0] clr;
  logic [4:0] nib;
  assign clr = file_data_in & ~(8'h01 << bit_sel_in);
  assign nib = acc_out[3:0] + file_data_in[3:0];
  //////////////////////////////////////////////////////////////////////////////
  chk_add_result: assert property (tk && op_in == op_add_acc_to_file && !dest_in |=>
    acc_out == $past(sum[7:0]) && carry_out == $past(sum[8])) else $error("add");
  chk_dest_file: assert property (tk && dest_in && op_in inside {op_add_acc_to_file,
    op_add_acc_file_with_carry, op_arith_shift_right_file} |=> file_we_out && $stable(acc_out)
    && file_addr_out == $past(file_addr_in)) else $error("dest");
  chk_shift_carry: assert property (tk && op_in == op_arith_shift_right_file |=>
    carry_out == $past(file_data_in[0]) && $stable(digit_carry_flag_out)) else $error("asr");
  chk_carry_add: assert property (tk && op_in == op_add_acc_file_with_carry && !dest_in |=>
    acc_out == $past(sum[7:0]) + $past(carry_out)) else $error("addc");
  chk_clear_flags: assert property (tk && op_in == op_clear_file_bit |=> file_we_out &&
    $stable({carry_out, digit_carry_flag_out, zero_out, acc_out})) else $error("clr");
  chk_clear_data: assert property (tk && op_in == op_clear_file_bit |=>
    file_wdata_out == $past(clr)) else $error("clr data");
  chk_skip_zero: assert property (tk && op_in == op_test_bit_skip_if_zero && !tb |=>
    discard_next_out && busy_out ##1 done_out && !discard_next_out) else $error("skz");
  chk_skip_one: assert property (tk && op_in == op_test_bit_skip_if_one |=>
    discard_next_out == $past(tb) && busy_out == $past(tb)) else $error("sko");
  chk_jump_target: assert property (tk && op_in == op_relative_jump |=> pc_load_out &&
    pc_target_out == $past(tgt) && $stable(carry_out)) else $error("jump");
  chk_nop_cycle: assert property (busy_out && clk_en_in |=>
    done_out && !busy_out && !file_we_out) else $error("nop");
  chk_zero_flag: assert property (tk && op_in == op_add_acc_to_file |=>
    zero_out == ($past(sum[7:0]) == 8'h00)) else $error("zero");
  chk_digit_carry: assert property (tk && op_in == op_add_acc_to_file |=>
    digit_carry_flag_out == $past(nib[4])) else $error("digit carry");
  cover property (tk && op_in == op_relative_jump);
  cover property (discard_next_out);
  cover property (tk && op_in == op_add_acc_file_with_carry && dest_in);
endmodule : bas_exec_checker
bind bas_exec bas_exec_checker #(.ADDR_BITS(ADDR_BITS), .PC_BITS(PC_BITS)) bas_exec_checker_inst (
  .core_clk_in, .reset_in, .clk_en_in, .start_in, .op_in, .file_addr_in, .dest_in, .bit_sel_in,
  .offset_in, .pc_in, .file_data_in, .acc_out, .carry_out, .digit_carry_flag_out, .zero_out,
  .file_we_out, .file_addr_out, .file_wdata_out, .pc_load_out, .pc_target_out,
  .discard_next_out, .busy_out, .done_out);
`default_nettype wire

// ===== verification/byte_alu_bit_skip_branch_exec_tb_top.sv
// random instruction stream against a reference model kept in the bench
// assumes bas_exec with default parameters and the checker bound to it
`timescale 1ns/1ps
`default_nettype none
module byte_alu_bit_skip_branch_exec_tb_top;
  import bas_pkg::*;
  logic clk = 0, rst = 1, en = 1, st = 0, dst = 0, c, dc, z, we, pl, dd, by, dn;
  bas_op_type op = op_no_operation;
  logic [6:0] fa = 0, fo, m_fa = 0;
  logic [2:0] bs = 0;
  logic [8:0] ofs = 0, s;
  logic [14:0] pc = 0, tg, m_tg = 0;
  logic [7:0] fd = 0, acc, wd, m_acc = 0, m_wd = 0;
  logic m_c = 0, m_dc = 0, m_z = 0;
  logic [63:0] rv;
  logic [40:0] q[$];
  int n_mismatch = 0, comparisons = 0, seed = 32'h137a;
  always #12.5 clk = ~clk;
  bas_exec bas_exec_inst (.core_clk_in(clk), .reset_in(rst), .clk_en_in(en), .start_in(st),
    .op_in(op), .file_addr_in(fa), .dest_in(dst), .bit_sel_in(bs), .offset_in(ofs),
    .pc_in(pc), .file_data_in(fd), .acc_out(acc), .carry_out(c), .digit_carry_flag_out(dc),
    .zero_out(z), .file_we_out(we), .file_addr_out(fo), .file_wdata_out(wd), .pc_load_out(pl),
    .pc_target_out(tg), .discard_next_out(dd), .busy_out(by), .done_out(dn));
  //////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [47:0] s_v, input logic [47:0] e);
    comparisons++;
    if (s_v !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", n, e, s_v);
    end
  endtask : chk
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // called at a falling edge; start stays high so single-cycle ops run back to back
  task automatic run(input bas_op_type o, input logic [8:0] k);
    logic sk, ci, w;
    rv = {$random(seed), $random(seed)};
    {fd, fa, dst, bs, pc} = rv[33:0];
    m_fa = fa;
    ofs = k;
    op = o;
    st = 1;
    sk = 0;
    s = 0;
    ci = (o == op_add_acc_file_with_carry) ? m_c : 1'b0;
    case (o)
      op_add_acc_to_file, op_add_acc_file_with_carry: begin
        s = m_acc + fd + ci;
        m_dc = (m_acc[3:0] + fd[3:0] + ci) > 15;
        m_c = s[8];
      end
      op_arith_shift_right_file: begin
        s = {1'b0, fd[7], fd[7:1]};
        m_c = fd[0];
      end
      op_clear_file_bit: m_wd = fd & ~(8'h01 << bs);
      op_test_bit_skip_if_zero: sk = !fd[bs];
      op_test_bit_skip_if_one: sk = fd[bs];
      op_relative_jump: m_tg = pc + PC_STEP + {{6{ofs[8]}}, ofs};
      default: ;
    endcase
    if (o inside {op_add_acc_to_file, op_add_acc_file_with_carry, op_arith_shift_right_file}) begin
      m_z = s[7:0] == 8'h00;
      if (dst) m_wd = s[7:0];
      else m_acc = s[7:0];
    end
    w = (o == op_clear_file_bit) || (dst && o inside {op_add_acc_to_file,
      op_add_acc_file_with_carry, op_arith_shift_right_file});
    q.push_back({m_acc, m_c, m_dc, m_z, m_wd, m_tg, m_fa});
    @(negedge clk);
    chk("discard", dd, sk);
    chk("busy", by, sk || o == op_relative_jump);
    chk("write", we, w);
    chk("pc_load", pl, o == op_relative_jump);
    if (by === 1'b1) begin
      @(negedge clk);
      chk("nop_cycle", {we, pl, dd, by}, 48'h0);
    end
  endtask : run
  //////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
    if (dn === 1'b1 && !rst) begin
      if (q.size() == 0) chk("spare_done", 48'h1, 48'h0);
      else chk("result", {acc, c, dc, z, wd, tg, fo}, q.pop_front());
    end
  initial begin
    repeat (2) @(negedge clk);
    rst = 0;
    @(negedge clk);
    repeat (300) run(bas_op_type'(3'($random(seed))), 9'($random(seed)));
    run(op_relative_jump, 9'h100);
    run(op_relative_jump, 9'h0ff);
    st = 0;
    @(negedge clk);
    // enable low: a start must be ignored and all state must hold
    en = 0;
    st = 1;
    op = op_add_acc_to_file;
    dst = DEST_ACC;
    fd = 8'h5a;
    repeat (2) @(negedge clk);
    chk("frozen", {acc, dn, we, by}, {m_acc, 3'b000});
    st = 0;
    @(negedge clk);
    en = 1;
    // reset in mid-run clears accumulator, flags and held outputs
    @(negedge clk);
    rst = 1;
    repeat (2) @(negedge clk);
    chk("reset", {acc, c, dc, z, wd, tg, fo, we, pl, dd, by, dn}, 48'h0);
    rst = 0;
    {m_acc, m_c, m_dc, m_z, m_wd, m_tg, m_fa} = 41'h0;
    @(negedge clk);
    run(op_add_acc_file_with_carry, 9'h000);
    st = 0;
    repeat (3) @(negedge clk);
    chk("pending", q.size(), 48'h0);
    give_verdict();
  end
  // the stream needs under a thousand cycles
  initial begin
    #50000;
    n_mismatch++;
    give_verdict();
  end
endmodule : byte_alu_bit_skip_branch_exec_tb_top
`default_nettype wire
